// ===== bacs_defines.vh
`ifndef BACS_DEFINES_VH
`define BACS_DEFINES_VH
// cpu operating modes
`define BACS_MODE_NORMAL      2'h0
`define BACS_MODE_MIDDLE      2'h1
`define BACS_MODE_ADVANCED    2'h2
`define BACS_MODE_MAXIMUM     2'h3
// address calculation kinds
`define BACS_CALC_PCREL8      3'h0
`define BACS_CALC_PCREL16     3'h1
`define BACS_CALC_PCIDX       3'h2
`define BACS_CALC_MEMIND      3'h3
`define BACS_CALC_EXTIND      3'h4
`define BACS_CALC_DATA        3'h5
`define BACS_CALC_STOREEA     3'h6
// index sizes
`define BACS_IDX_BYTE         2'h0
`define BACS_IDX_WORD         2'h1
`define BACS_IDX_LONG         2'h2
// extended indirect offset added to the 7-bit field
`define BACS_EXT_BASE         8'h80
// processing states
`define BACS_ST_RESET         3'h0
`define BACS_ST_EXCEPTION     3'h1
`define BACS_ST_EXECUTE       3'h2
`define BACS_ST_BUS_RELEASED  3'h3
`define BACS_ST_STOP          3'h4
// exception vector numbers that ignore the vector base register
`define BACS_VEC_RESET        8'h00
`define BACS_VEC_ADDR_ERR     8'h09
`endif

// ===== bacs_sync2.v
`timescale 1ns/1ps
`include "bacs_defines.vh"
module bacs_sync2 (
    input  wire clk_in,
    input  wire d_in,
    output wire q_out
);
    reg stage1_reg;
    reg stage2_reg;
    // first stage feeds only the second stage
    always @(posedge clk_in) begin
        stage1_reg <= d_in;
        stage2_reg <= stage1_reg;
    end
    assign q_out = stage2_reg;
endmodule

// ===== bacs_branch_addr_cpu.v
`timescale 1ns/1ps
`include "bacs_defines.vh"
module bacs_branch_addr_cpu (
    input  wire        REF_CLK_IN,
    input  wire        SYS_RST_IN,
    input  wire        RESET_N_IN,
    input  wire        WDT_OVERFLOW_IN,
    input  wire        MODE_PIN_HIGH_IN,
    input  wire        MODE_PIN_LOW_IN,
    input  wire        DMA_BUS_REQ_IN,
    input  wire        EXC_REQ_IN,
    input  wire [7:0]  EXC_VECTOR_IN,
    input  wire        SLEEP_IN,
    input  wire        STANDBY_IN,
    input  wire        WAKE_IN,
    input  wire [31:0] VECTOR_BASE_IN,
    input  wire        CALC_REQ_IN,
    input  wire [2:0]  CALC_KIND_IN,
    input  wire [1:0]  CPU_MODE_IN,
    input  wire [31:0] NEXT_PC_IN,
    input  wire [15:0] DISP_IN,
    input  wire [31:0] INDEX_IN,
    input  wire [1:0]  INDEX_SIZE_IN,
    input  wire [7:0]  ABS8_IN,
    input  wire [6:0]  VEC7_IN,
    input  wire [31:0] DATA_EA_IN,
    input  wire [31:0] MEM_RDATA_IN,
    input  wire        MEM_ACK_IN,
    output reg         MEM_REQ_OUT,
    output reg  [31:0] MEM_ADDR_OUT,
    output reg         MEM_LONG_OUT,
    output reg         CALC_DONE_OUT,
    output reg  [31:0] CALC_RESULT_OUT,
    output reg  [2:0]  PROC_STATE_OUT,
    output reg         INT_MASK_OUT,
    output reg         BUS_GRANT_OUT,
    output reg         CPU_RUN_OUT,
    output reg  [1:0]  CPU_MODE_OUT,
    output reg  [1:0]  INIT_FLAVOUR_OUT
);
    // ****************************************************
    // pin synchronisers
    // ****************************************************
    wire reset_n_sync;
    wire dma_req_sync;
    wire mode_hi_sync;
    wire mode_lo_sync;

    bacs_sync2 u_sync_rst (
        .clk_in (REF_CLK_IN),
        .d_in   (RESET_N_IN),
        .q_out  (reset_n_sync)
    );
    bacs_sync2 u_sync_dma (
        .clk_in (REF_CLK_IN),
        .d_in   (DMA_BUS_REQ_IN),
        .q_out  (dma_req_sync)
    );
    bacs_sync2 u_sync_mhi (
        .clk_in (REF_CLK_IN),
        .d_in   (MODE_PIN_HIGH_IN),
        .q_out  (mode_hi_sync)
    );
    bacs_sync2 u_sync_mlo (
        .clk_in (REF_CLK_IN),
        .d_in   (MODE_PIN_LOW_IN),
        .q_out  (mode_lo_sync)
    );

    // ****************************************************
    // address arithmetic
    // ****************************************************
    reg  [31:0] disp_ext;
    reg  [31:0] idx_ext;
    reg  [31:0] branch_raw;
    wire [31:0] ext_ptr;
    wire [7:0]  ext_sum;

    // sign-extend displacement, zero-extend index by size
    always @* begin
        if (CALC_KIND_IN == `BACS_CALC_PCREL8) begin
            disp_ext = {{24{DISP_IN[7]}}, DISP_IN[7:0]};
        end else begin
            disp_ext = {{16{DISP_IN[15]}}, DISP_IN};
        end
        case (INDEX_SIZE_IN)
            `BACS_IDX_BYTE: idx_ext = {24'h000000, INDEX_IN[7:0]};
            `BACS_IDX_WORD: idx_ext = {16'h0000, INDEX_IN[15:0]};
            default:        idx_ext = INDEX_IN;
        endcase
    end

    // next-instruction pc is the base, so short reach is -128..+127 from it
    always @* begin
        if (CALC_KIND_IN == `BACS_CALC_PCIDX) begin
            branch_raw = NEXT_PC_IN + {idx_ext[30:0], 1'b0};
        end else begin
            branch_raw = NEXT_PC_IN + disp_ext;
        end
    end

    // field plus 0x80, scaled: lands in 0x100-0x1FF or 0x200-0x3FF
    assign ext_sum = {1'b0, VEC7_IN} + `BACS_EXT_BASE;
    assign ext_ptr = (CPU_MODE_IN == `BACS_MODE_NORMAL) ?
                     {23'h000000, ext_sum, 1'b0} :
                     {22'h000000, ext_sum, 2'h0};

    // mode masking of a branch target
    function [31:0] mask_branch;
        input [31:0] addr;
        input [1:0]  mode;
        begin
            case (mode)
                `BACS_MODE_NORMAL:   mask_branch = {16'h0000, addr[15:0]};
                `BACS_MODE_MIDDLE:   mask_branch = {8'h00, addr[23:0]};
                `BACS_MODE_ADVANCED: mask_branch = {8'h00, addr[23:0]};
                default:             mask_branch = addr;
            endcase
        end
    endfunction

    // mode masking of a data effective address
    function [31:0] mask_data;
        input [31:0] addr;
        input [1:0]  mode;
        begin
            case (mode)
                `BACS_MODE_NORMAL:   mask_data = {16'h0000, addr[15:0]};
                `BACS_MODE_MIDDLE:
                    mask_data = {{16{addr[15]}}, addr[15:0]};
                `BACS_MODE_ADVANCED: mask_data = {8'h00, addr[23:0]};
                default:             mask_data = addr;
            endcase
        end
    endfunction

    // ****************************************************
    // calculation sequencer
    // ****************************************************
    localparam [1:0] C_IDLE  = 2'h0;
    localparam [1:0] C_FETCH = 2'h1;
    localparam [1:0] C_DONE  = 2'h2;
    localparam [1:0] C_VEC   = 2'h3; // exception vector fetch

    reg [1:0]  calc_state_reg;
    reg [2:0]  kind_reg;
    reg [1:0]  mode_reg;
    reg [31:0] fetched;
    reg        vec_reset_reg; // exception came from the reset state
    wire       in_exc = (PROC_STATE_OUT == `BACS_ST_EXCEPTION);
    wire       running;
    wire [31:0] vec_addr;

    // a fetched target keeps 16 bits in normal mode, 24 in middle and advanced, 32 in maximum
    always @* begin
        if (mode_reg == `BACS_MODE_NORMAL) begin
            fetched = {16'h0000, MEM_RDATA_IN[15:0]};
        end else if (mode_reg == `BACS_MODE_MAXIMUM) begin
            fetched = MEM_RDATA_IN;
        end else begin
            fetched = {8'h00, MEM_RDATA_IN[23:0]};
        end
    end

    // vectors relocate except reset and address error; reset origin uses 0
    assign vec_addr = vec_reset_reg ? {22'h000000, `BACS_VEC_RESET, 2'h0} :
                      ((EXC_VECTOR_IN == `BACS_VEC_RESET) ||
                       (EXC_VECTOR_IN == `BACS_VEC_ADDR_ERR)) ?
                      {22'h000000, EXC_VECTOR_IN, 2'h0} :
                      VECTOR_BASE_IN + {22'h000000, EXC_VECTOR_IN, 2'h0};

    // calculations start only while executing; exception state fetches its vector
    always @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN || !(running || in_exc)) begin
            calc_state_reg  <= C_IDLE;
            kind_reg        <= 3'h0;
            mode_reg        <= `BACS_MODE_ADVANCED;
            MEM_REQ_OUT     <= 1'b0;
            MEM_ADDR_OUT    <= 32'h00000000;
            MEM_LONG_OUT    <= 1'b0;
            CALC_DONE_OUT   <= 1'b0;
            CALC_RESULT_OUT <= 32'h00000000;
        end else begin
            CALC_DONE_OUT <= 1'b0;
            case (calc_state_reg)
                C_IDLE: begin
                    if (in_exc) begin
                        MEM_ADDR_OUT   <= vec_addr;
                        MEM_LONG_OUT   <= 1'b1;
                        MEM_REQ_OUT    <= 1'b1;
                        calc_state_reg <= C_VEC;
                    end else if (CALC_REQ_IN) begin
                        kind_reg <= CALC_KIND_IN;
                        mode_reg <= CPU_MODE_IN;
                        MEM_LONG_OUT <= (CPU_MODE_IN != `BACS_MODE_NORMAL);
                        case (CALC_KIND_IN)
                            `BACS_CALC_MEMIND: begin
                                MEM_ADDR_OUT <= {24'h000000, ABS8_IN};
                                MEM_REQ_OUT  <= 1'b1;
                                calc_state_reg <= C_FETCH;
                            end
                            `BACS_CALC_EXTIND: begin
                                MEM_ADDR_OUT <= ext_ptr;
                                MEM_REQ_OUT  <= 1'b1;
                                calc_state_reg <= C_FETCH;
                            end
                            `BACS_CALC_STOREEA: begin
                                // operand fetched first by data mode
                                MEM_ADDR_OUT <= mask_data(DATA_EA_IN,
                                                          CPU_MODE_IN);
                                MEM_LONG_OUT <= 1'b1;
                                MEM_REQ_OUT  <= 1'b1;
                                calc_state_reg <= C_FETCH;
                            end
                            `BACS_CALC_DATA: begin
                                CALC_RESULT_OUT <= mask_data(DATA_EA_IN,
                                                             CPU_MODE_IN);
                                calc_state_reg  <= C_DONE;
                            end
                            default: begin
                                CALC_RESULT_OUT <= mask_branch(branch_raw,
                                                               CPU_MODE_IN);
                                calc_state_reg  <= C_DONE;
                            end
                        endcase
                    end
                end
                C_FETCH: begin
                    if (MEM_ACK_IN) begin
                        MEM_REQ_OUT <= 1'b0;
                        if (kind_reg == `BACS_CALC_STOREEA) begin
                            // operand stands in for the index register
                            CALC_RESULT_OUT <= mask_data(MEM_RDATA_IN +
                                {{16{DISP_IN[15]}}, DISP_IN},
                                mode_reg);
                        end else begin
                            CALC_RESULT_OUT <= fetched;
                        end
                        calc_state_reg <= C_DONE;
                    end
                end
                C_DONE: begin
                    CALC_DONE_OUT  <= 1'b1;
                    calc_state_reg <= C_IDLE;
                end
                C_VEC: if (MEM_ACK_IN) begin
                    MEM_REQ_OUT    <= 1'b0;
                    calc_state_reg <= C_IDLE;
                end
                default: calc_state_reg <= C_IDLE;
            endcase
        end
    end

    // ****************************************************
    // processing-state sequencer
    // ****************************************************
    reg       rst_n_prev_reg;
    reg [2:0] next_state;
    assign running = (PROC_STATE_OUT == `BACS_ST_EXECUTE);

    // five states only; reset pin or watchdog always wins
    always @* begin
        next_state = PROC_STATE_OUT;
        if (!reset_n_sync || WDT_OVERFLOW_IN) begin
            next_state = `BACS_ST_RESET;
        end else begin
            case (PROC_STATE_OUT)
                `BACS_ST_RESET:
                    if (!rst_n_prev_reg)
                        next_state = `BACS_ST_EXCEPTION;
                `BACS_ST_EXCEPTION:
                    if (calc_state_reg == C_VEC && MEM_ACK_IN)
                        next_state = `BACS_ST_EXECUTE;
                `BACS_ST_EXECUTE:
                    if (dma_req_sync)
                        next_state = `BACS_ST_BUS_RELEASED;
                    else if (EXC_REQ_IN)
                        next_state = `BACS_ST_EXCEPTION;
                    else if (SLEEP_IN || STANDBY_IN)
                        next_state = `BACS_ST_STOP;
                `BACS_ST_BUS_RELEASED:
                    if (!dma_req_sync)
                        next_state = `BACS_ST_EXECUTE;
                `BACS_ST_STOP:
                    if (WAKE_IN)
                        next_state = `BACS_ST_EXCEPTION;
                default: next_state = `BACS_ST_RESET;
            endcase
        end
    end

    // the mode pins only pick the start flavour; cpu mode is fixed
    always @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            PROC_STATE_OUT   <= `BACS_ST_RESET;
            rst_n_prev_reg   <= 1'b0;
            INT_MASK_OUT     <= 1'b1;
            BUS_GRANT_OUT    <= 1'b0;
            CPU_RUN_OUT      <= 1'b0;
            CPU_MODE_OUT     <= `BACS_MODE_ADVANCED;
            INIT_FLAVOUR_OUT <= 2'h0;
        end else begin
            PROC_STATE_OUT <= next_state;
            rst_n_prev_reg <= reset_n_sync && !WDT_OVERFLOW_IN;
            vec_reset_reg  <= in_exc ? vec_reset_reg :
                              (PROC_STATE_OUT == `BACS_ST_RESET);
            CPU_MODE_OUT   <= `BACS_MODE_ADVANCED;
            if (PROC_STATE_OUT == `BACS_ST_RESET) begin
                INIT_FLAVOUR_OUT <= {mode_hi_sync, mode_lo_sync};
            end
            INT_MASK_OUT  <= (next_state == `BACS_ST_RESET);
            BUS_GRANT_OUT <= (next_state == `BACS_ST_BUS_RELEASED);
            CPU_RUN_OUT   <= (next_state == `BACS_ST_EXECUTE) ||
                             (next_state == `BACS_ST_EXCEPTION);
        end
    end
endmodule

// ===== bacs_mem_model.sv
`timescale 1ns/1ps
// ************************************************
// far-side memory: answers each fetch after a delay
// ************************************************
module bacs_mem_model (
    input  wire        clk_in,
    input  wire        req_in,
    input  wire [31:0] data_cfg_in,
    input  wire [3:0]  delay_in,
    output reg         ack_out,
    output reg  [31:0] rdata_out
);
    reg [3:0] cnt_reg;
    // one ack pulse per request; bus toggles when no data is valid,
    // so a stale read one cycle after the ack never looks like a good one
    always @(posedge clk_in) begin
        if (req_in && !ack_out && cnt_reg == delay_in) begin
            ack_out   <= 1'b1;
            rdata_out <= data_cfg_in;
            cnt_reg   <= 4'h0;
        end else begin
            ack_out   <= 1'b0;
            rdata_out <= ~rdata_out;
            cnt_reg   <= (req_in && !ack_out) ? cnt_reg + 4'h1 : 4'h0;
        end
    end
    initial begin
        ack_out   = 1'b0;
        rdata_out = 32'h5A5A_5A5A;
        cnt_reg   = 4'h0;
    end
endmodule

// ===== bacs_assertions.sv
`timescale 1ns/1ps
// ************************************************
// port checker
// ************************************************
module bacs_assertions (
    input wire        REF_CLK_IN,
    input wire        SYS_RST_IN,
    input wire        RESET_N_IN,
    input wire        WDT_OVERFLOW_IN,
    input wire [2:0]  CALC_KIND_IN,
    input wire [1:0]  CPU_MODE_IN,
    input wire [31:0] NEXT_PC_IN,
    input wire [15:0] DISP_IN,
    input wire [7:0]  ABS8_IN,
    input wire [6:0]  VEC7_IN,
    input wire        MEM_REQ_OUT,
    input wire [31:0] MEM_ADDR_OUT,
    input wire        MEM_LONG_OUT,
    input wire        CALC_DONE_OUT,
    input wire [31:0] CALC_RESULT_OUT,
    input wire [2:0]  PROC_STATE_OUT,
    input wire        INT_MASK_OUT,
    input wire        BUS_GRANT_OUT,
    input wire        CPU_RUN_OUT,
    input wire [1:0]  CPU_MODE_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // fetches are judged only when raised by a calculation
    wire ex = PROC_STATE_OUT == 3'h2;
    AST_MODE_FIXED: assert property (CPU_MODE_OUT == 2'h2)
        else $error("cpu mode not advanced");
    AST_STATE_RANGE: assert property (PROC_STATE_OUT <= 3'h4)
        else $error("state out of range");
    // four cycles cover the two-flop pin synchroniser
    AST_PIN_RESET: assert property ((!RESET_N_IN)[*4] |->
        PROC_STATE_OUT == 3'h0 && INT_MASK_OUT) else $error("pin reset");
    AST_WDT_RESET: assert property (WDT_OVERFLOW_IN |->
        ##[1:2] PROC_STATE_OUT == 3'h0) else $error("watchdog reset");
    AST_BUS_REL: assert property (PROC_STATE_OUT == 3'h3 |->
        BUS_GRANT_OUT && !CPU_RUN_OUT) else $error("bus release");
    AST_STOP: assert property (PROC_STATE_OUT == 3'h4 |->
        !CPU_RUN_OUT && !BUS_GRANT_OUT) else $error("stop state");
    AST_IND_PTR: assert property ($rose(MEM_REQ_OUT) && ex
        && CALC_KIND_IN == 3'h3 |-> MEM_ADDR_OUT == {24'h0, ABS8_IN}
        && MEM_LONG_OUT == (CPU_MODE_IN != 2'h0)) else $error("ind ptr");
    AST_EXT_PTR: assert property ($rose(MEM_REQ_OUT) && ex
        && CALC_KIND_IN == 3'h4 |-> MEM_ADDR_OUT == (CPU_MODE_IN == 2'h0 ?
        {23'h0, 1'b1, VEC7_IN, 1'b0} : {22'h0, 1'b1, VEC7_IN, 2'h0}))
        else $error("ext ptr");
    AST_PCREL8: assert property (CALC_DONE_OUT && CALC_KIND_IN == 3'h0
        && CPU_MODE_IN == 2'h3 |-> CALC_RESULT_OUT == NEXT_PC_IN
        + {{24{DISP_IN[7]}}, DISP_IN[7:0]}) else $error("pc rel8");
    AST_ADV_TOP: assert property (CALC_DONE_OUT && CPU_MODE_IN == 2'h2
        && CALC_KIND_IN <= 3'h4 |-> CALC_RESULT_OUT[31:24] == 8'h00)
        else $error("adv top byte");
    AST_DONE_PULSE: assert property (CALC_DONE_OUT |=> !CALC_DONE_OUT)
        else $error("done not a pulse");
endmodule
bind bacs_branch_addr_cpu bacs_assertions u_chk (.REF_CLK_IN, .SYS_RST_IN,
    .RESET_N_IN, .WDT_OVERFLOW_IN, .CALC_KIND_IN, .CPU_MODE_IN, .NEXT_PC_IN,
    .DISP_IN, .ABS8_IN, .VEC7_IN, .MEM_REQ_OUT, .MEM_ADDR_OUT, .MEM_LONG_OUT,
    .CALC_DONE_OUT, .CALC_RESULT_OUT, .PROC_STATE_OUT, .INT_MASK_OUT,
    .BUS_GRANT_OUT, .CPU_RUN_OUT, .CPU_MODE_OUT);

// ===== bacs_branch_addr_cpu_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    err_count++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module bacs_branch_addr_cpu_tb;
    logic REF_CLK_IN, SYS_RST_IN, RESET_N_IN, WDT_OVERFLOW_IN, CALC_REQ_IN;
    logic MODE_PIN_HIGH_IN, MODE_PIN_LOW_IN, DMA_BUS_REQ_IN, EXC_REQ_IN;
    logic SLEEP_IN, STANDBY_IN, WAKE_IN, MEM_ACK_IN, MEM_REQ_OUT, MEM_LONG_OUT;
    logic CALC_DONE_OUT, INT_MASK_OUT, BUS_GRANT_OUT, CPU_RUN_OUT;
    logic [7:0]  EXC_VECTOR_IN, ABS8_IN;
    logic [31:0] VECTOR_BASE_IN, NEXT_PC_IN, INDEX_IN, DATA_EA_IN, mem_data;
    logic [31:0] MEM_RDATA_IN, MEM_ADDR_OUT, CALC_RESULT_OUT, addr_seen;
    logic [2:0]  CALC_KIND_IN, PROC_STATE_OUT;
    logic [1:0]  CPU_MODE_IN, INDEX_SIZE_IN, CPU_MODE_OUT, INIT_FLAVOUR_OUT;
    logic [15:0] DISP_IN;
    logic [6:0]  VEC7_IN;
    logic [3:0]  mem_delay;
    int err_count = 0;
    int compares = 0;
    bacs_branch_addr_cpu uut (.REF_CLK_IN, .SYS_RST_IN, .RESET_N_IN,
        .WDT_OVERFLOW_IN, .MODE_PIN_HIGH_IN, .MODE_PIN_LOW_IN, .DMA_BUS_REQ_IN,
        .EXC_REQ_IN, .EXC_VECTOR_IN, .SLEEP_IN, .STANDBY_IN, .WAKE_IN,
        .VECTOR_BASE_IN, .CALC_REQ_IN, .CALC_KIND_IN, .CPU_MODE_IN, .NEXT_PC_IN,
        .DISP_IN, .INDEX_IN, .INDEX_SIZE_IN, .ABS8_IN, .VEC7_IN, .DATA_EA_IN,
        .MEM_RDATA_IN, .MEM_ACK_IN, .MEM_REQ_OUT, .MEM_ADDR_OUT, .MEM_LONG_OUT,
        .CALC_DONE_OUT, .CALC_RESULT_OUT, .PROC_STATE_OUT, .INT_MASK_OUT,
        .BUS_GRANT_OUT, .CPU_RUN_OUT, .CPU_MODE_OUT, .INIT_FLAVOUR_OUT);
    bacs_mem_model u_mem (.clk_in(REF_CLK_IN), .req_in(MEM_REQ_OUT),
        .data_cfg_in(mem_data), .delay_in(mem_delay), .ack_out(MEM_ACK_IN),
        .rdata_out(MEM_RDATA_IN));
    initial begin
        REF_CLK_IN = 1'b0;
        forever #4 REF_CLK_IN = ~REF_CLK_IN;
    end
    task automatic conclude;
        if (err_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one guarded cycle of a bounded wait; a hang ends the run
    task automatic step(inout int n);
        @(negedge REF_CLK_IN);
        n++;
        if (n > 300) begin
            `CHK("wait_bound", 1, 0)
            conclude;
        end
    endtask
    task automatic wait_state(input logic [2:0] st);
        int n = 0;
        while (PROC_STATE_OUT !== st) step(n);
    endtask
    task automatic wait_mem;
        int n = 0;
        while (MEM_REQ_OUT !== 1'b1) step(n);
        addr_seen = MEM_ADDR_OUT;
    endtask
    // kind and mode stay put until done so the checker sees the cause; the request is a one-cycle pulse
    task automatic calc(input logic [2:0] k, input logic [1:0] m,
                        input logic [31:0] exp);
        int n = 0;
        CALC_KIND_IN = k;
        CPU_MODE_IN = m;
        CALC_REQ_IN = 1'b1;
        @(negedge REF_CLK_IN);
        CALC_REQ_IN = 1'b0;
        while (CALC_DONE_OUT !== 1'b1) begin
            if (MEM_REQ_OUT === 1'b1) addr_seen = MEM_ADDR_OUT;
            step(n);
        end
        `CHK("calc_result", exp, CALC_RESULT_OUT)
        @(negedge REF_CLK_IN);
    endtask
    task automatic t_relative;
        NEXT_PC_IN = 32'h1234_0100;
        DISP_IN = 16'h0080;
        calc(3'h0, 2'h3, 32'h1234_0080);
        calc(3'h0, 2'h2, 32'h0034_0080);
        DISP_IN = 16'h8002;
        calc(3'h1, 2'h1, 32'h0033_8102);
        calc(3'h1, 2'h2, 32'h0033_8102);
        INDEX_IN = 32'hFFFF_FF81;
        INDEX_SIZE_IN = 2'h0;
        calc(3'h2, 2'h3, 32'h1234_0202);
        INDEX_SIZE_IN = 2'h1;
        calc(3'h2, 2'h3, 32'h1236_0002);
        INDEX_SIZE_IN = 2'h2;
        calc(3'h2, 2'h2, 32'h0034_0002);
    endtask
    task automatic t_indirect;
        ABS8_IN = 8'hFF;
        VEC7_IN = 7'h7F;
        mem_data = 32'hA5B6_C7D8;
        mem_delay = 4'h3;
        calc(3'h3, 2'h0, 32'h0000_C7D8);
        `CHK("ind_addr", 32'h0000_00FF, addr_seen)
        calc(3'h3, 2'h1, 32'h00B6_C7D8);
        calc(3'h3, 2'h3, 32'hA5B6_C7D8);
        mem_delay = 4'h0;
        calc(3'h4, 2'h0, 32'h0000_C7D8);
        `CHK("ext_addr", 32'h0000_01FE, addr_seen)
        calc(3'h4, 2'h2, 32'h00B6_C7D8);
        `CHK("ext_addr", 32'h0000_03FC, addr_seen)
    endtask
    task automatic t_data;
        DATA_EA_IN = 32'h0012_8000;
        calc(3'h5, 2'h1, 32'hFFFF_8000);
        DATA_EA_IN = 32'h0012_7FFF;
        calc(3'h5, 2'h1, 32'h0000_7FFF);
        DISP_IN = 16'h0010;
        mem_data = 32'h0000_7FF8;
        calc(3'h6, 2'h1, 32'hFFFF_8008);
    endtask
    task automatic exc(input logic [7:0] v, input logic [31:0] exp);
        EXC_VECTOR_IN = v;
        EXC_REQ_IN = 1'b1;
        wait_state(3'h1);
        EXC_REQ_IN = 1'b0;
        wait_mem;
        `CHK("vector_addr", exp, addr_seen)
        wait_state(3'h2);
    endtask
    task automatic t_states;
        DMA_BUS_REQ_IN = 1'b1;
        wait_state(3'h3);
        repeat (5) @(negedge REF_CLK_IN);
        `CHK("bus_grant", 1'b1, BUS_GRANT_OUT)
        DMA_BUS_REQ_IN = 1'b0;
        wait_state(3'h2);
        `CHK("cpu_run", 1'b1, CPU_RUN_OUT)
        for (int i = 0; i < 2; i++) begin
            SLEEP_IN = (i == 0);
            STANDBY_IN = (i == 1);
            wait_state(3'h4);
            SLEEP_IN = 1'b0;
            STANDBY_IN = 1'b0;
            WAKE_IN = 1'b1;
            wait_state(3'h1);
            WAKE_IN = 1'b0;
            wait_state(3'h2);
        end
        VECTOR_BASE_IN = 32'h0000_1000;
        exc(8'h05, 32'h0000_1014);
        exc(8'h09, 32'h0000_0024);
        // watchdog in mid-fetch must abort the calculation
        mem_delay = 4'hF;
        CALC_KIND_IN = 3'h3;
        CALC_REQ_IN = 1'b1;
        @(negedge REF_CLK_IN);
        CALC_REQ_IN = 1'b0;
        WDT_OVERFLOW_IN = 1'b1;
        @(negedge REF_CLK_IN);
        WDT_OVERFLOW_IN = 1'b0;
        wait_state(3'h0);
        // the fetch is dropped one edge after the state changes
        @(negedge REF_CLK_IN);
        `CHK("fetch_abort", 1'b0, MEM_REQ_OUT)
        mem_delay = 4'h0;
        wait_state(3'h2);
        {MODE_PIN_HIGH_IN, MODE_PIN_LOW_IN} = 2'h1;
        RESET_N_IN = 1'b0;
        repeat (6) @(negedge REF_CLK_IN);
        `CHK("int_mask", 1'b1, INT_MASK_OUT)
        `CHK("flavour", 2'h1, INIT_FLAVOUR_OUT)
        RESET_N_IN = 1'b1;
        wait_state(3'h1);
        wait_mem;
        `CHK("reset_vector", 32'h0000_0000, addr_seen)
        wait_state(3'h2);
    endtask
    initial begin
        {SYS_RST_IN, RESET_N_IN, MODE_PIN_HIGH_IN} = 3'h7;
        {WDT_OVERFLOW_IN, MODE_PIN_LOW_IN, DMA_BUS_REQ_IN, EXC_REQ_IN} = 4'h0;
        {SLEEP_IN, STANDBY_IN, WAKE_IN, CALC_REQ_IN, mem_delay} = 8'h00;
        {EXC_VECTOR_IN, ABS8_IN, VEC7_IN, DISP_IN} = 39'h0;
        {VECTOR_BASE_IN, NEXT_PC_IN, INDEX_IN, DATA_EA_IN} = 128'h0;
        {CALC_KIND_IN, CPU_MODE_IN, INDEX_SIZE_IN, mem_data} = 39'h0;
        addr_seen = 32'h0;
        repeat (16) @(negedge REF_CLK_IN);
        SYS_RST_IN = 1'b0;
        wait_state(3'h2);
        `CHK("flavour", 2'h2, INIT_FLAVOUR_OUT)
        `CHK("cpu_mode", 2'h2, CPU_MODE_OUT)
        t_relative;
        t_indirect;
        t_data;
        t_states;
        conclude;
    end
endmodule
